// *** verilog/crt_reel_timer_trio.sv ***
// Three cascaded 8-bit down-counters for capstan and reel control.
// Assumes pulse pins are asynchronous and software strobes are on core_clk_i.
//
// Operation
// - Reload write also loads counter at once
// - Reload mode underflow copies reload into counter
// - First and second counters capture jointly, 16 bits
// - Option: capture also clears counter
// - First capture trigger: FG or reel edge
// - Capture can raise third timer interrupt
// - Second counter: 8-bit, reload and capture registers
// - Second clock: first underflow or divided clocks
// - Second reload optional; writes still load counter
// - Second underflow raises second timer interrupt outside acceleration
// - Reset sets counters, reload and capture registers to ones; mode registers to zero
// - Second capture: FG, reel or third underflow
// - Third counter: 8-bit, reload, no capture
// - Third reload: underflow or control edge per source
// - Acceleration underflow sets FG mask; FG reloads timer
// - Acceleration FG before underflow reloads and interrupts
// - Braking FG before underflow keeps reloading
// - Braking underflow raises interrupt
// - Divided third counter gives slow-track delay interrupt
// - Third underflow captures second counter for identification
// - Reset selects mode identification configuration
// - First clock: FG edge or divided clocks
// - First underflow raises first timer interrupt
// - Third interrupt ORs capture and slow-track flags
// - Flag clears by zero after reading one; capture and slow-track flags also clear on a CPSLM change
`default_nettype none
`include "crt_defs.svh"
module crt_reel_timer_trio
  import crt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic fg_pulse_i,
  input wire logic reel_pulse_input_i,
  input wire logic divided_ctl_pulse_i,
  input wire logic [2:0] load_wr_i,
  input wire logic [7:0] load_data_i,
  input wire logic mode_one_wr_i,
  input wire logic mode_two_wr_i,
  input wire logic [7:0] mode_data_i,
  input wire logic flag_rd_i,
  input wire logic flag_wr_i,
  input wire logic [`CRT_NFLAG-1:0] flag_data_i,
  output logic [7:0] fg_divide_counter_o,
  output logic [7:0] capture_speed_counter_o,
  output logic [7:0] ctl_divide_counter_o,
  output logic [7:0] capture_one_o,
  output logic [7:0] capture_two_o,
  output logic [7:0] timer_mode_reg_one_o,
  output logic [7:0] timer_mode_reg_two_o,
  output logic [`CRT_NFLAG-1:0] flags_o,
  output logic fg_mask_o
);
  crt_byte_t cnt1_q;
  crt_byte_t cnt2_q;
  crt_byte_t cnt3_q;
  crt_byte_t cap1_q;
  crt_byte_t cap2_q;
  crt_byte_t load_q [3];
  crt_byte_t mode1_q;
  crt_byte_t mode2_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [`CRT_PRE_W-1:0] pre_q;
  logic fg_mask_q;
  logic armed3_q;

  logic fg_edge;
  logic reel_edge;
  logic ctl_edge;
  logic [2:0] div;
  logic tick1;
  logic tick2;
  logic tick3;
  logic uf1;
  logic uf2;
  logic uf3;
  logic pin_cap;
  logic cap1;
  logic cap2;
  logic cap_mode1;
  logic clr_on_cap;
  logic rld2;
  logic ab_mode;
  logic accel;
  logic fg_rl2;
  logic ctl_clk;
  logic reload3;
  logic slw_ev;
  logic cp_slm;
  crt_src_e ps1;
  crt_src_e ps2;
  crt_src_e ps3;

  crt_flag_if fi ();

  function automatic logic pick_tick(input crt_src_e sel, input logic evt,
                                     input logic [2:0] dv);
    case (sel)
      CRT_SRC_EVT: pick_tick = evt;
      CRT_SRC_DIV_A: pick_tick = dv[0];
      CRT_SRC_DIV_B: pick_tick = dv[1];
      default: pick_tick = dv[2];
    endcase
  endfunction

  // Pin synchronisers; only the second and third stages feed logic
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {divided_ctl_pulse_i, reel_pulse_input_i, fg_pulse_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign fg_edge = pin_s2_q[0] & ~pin_s3_q[0];
  assign reel_edge = pin_s2_q[1] & ~pin_s3_q[1];
  assign ctl_edge = pin_s2_q[2] & ~pin_s3_q[2];

  // Free-running prescaler giving the three divided clocks
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + `CRT_PRE_W'(1);
    end
  end

  assign div[0] = (pre_q[1:0] == 2'(`CRT_DIV_A));
  assign div[1] = (pre_q[3:0] == 4'(`CRT_DIV_B));
  assign div[2] = (pre_q == `CRT_DIV_C);

  // Mode registers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode1_q <= `CRT_MODE_ONE_RST;
      mode2_q <= `CRT_MODE_TWO_RST;
    end else begin
      if (mode_one_wr_i) begin
        mode1_q <= mode_data_i;
      end
      if (mode_two_wr_i) begin
        mode2_q <= mode_data_i;
      end
    end
  end

  assign ps1 = crt_src_e'(mode2_q[`CRT_M2_PS1_HI:`CRT_M2_PS1_LO]);
  assign ps2 = crt_src_e'(mode1_q[`CRT_M1_PS2_HI:`CRT_M1_PS2_LO]);
  assign ps3 = crt_src_e'(mode2_q[`CRT_M2_PS3_HI:`CRT_M2_PS3_LO]);
  assign cap_mode1 = mode1_q[`CRT_M1_RLDCAP];
  assign clr_on_cap = mode1_q[`CRT_M1_CLR];
  assign rld2 = mode1_q[`CRT_M1_RLD];
  assign ab_mode = rld2 & ~mode1_q[`CRT_M1_RLCK];
  assign accel = ab_mode & mode1_q[`CRT_M1_ACBR];
  assign cp_slm = mode2_q[`CRT_M2_CPSLM];
  assign ctl_clk = (ps3 == CRT_SRC_EVT);

  // Reload registers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 3; i++) begin
        load_q[i] <= `CRT_ALL_ONES;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (load_wr_i[i]) begin
          load_q[i] <= load_data_i;
        end
      end
    end
  end

  // First counter
  assign tick1 = pick_tick(ps1, fg_edge, div);
  assign uf1 = tick1 && (cnt1_q == `CRT_ZERO);
  assign pin_cap = mode1_q[`CRT_M1_CPS] ? reel_edge : fg_edge;
  assign cap1 = cap_mode1 && pin_cap;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt1_q <= `CRT_ALL_ONES;
    end else if (load_wr_i[0]) begin
      cnt1_q <= load_data_i;
    end else if (cap1 && clr_on_cap) begin
      cnt1_q <= `CRT_ALL_ONES;
    end else if (uf1) begin
      cnt1_q <= cap_mode1 ? `CRT_ALL_ONES : load_q[0];
    end else if (tick1) begin
      cnt1_q <= cnt1_q - 8'h01;
    end
  end

  // Second counter
  assign tick2 = pick_tick(ps2, uf1, div);
  assign fg_rl2 = ab_mode && fg_edge;
  // An FG edge in the underflow cycle counts as arriving in time
  assign uf2 = tick2 && (cnt2_q == `CRT_ZERO) && !fg_rl2;
  assign cap2 = mode2_q[`CRT_M2_LAT] ? pin_cap : uf3;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt2_q <= `CRT_ALL_ONES;
    end else if (load_wr_i[1]) begin
      cnt2_q <= load_data_i;
    end else if (cap2 && clr_on_cap) begin
      cnt2_q <= `CRT_ALL_ONES;
    end else if (fg_rl2) begin
      cnt2_q <= load_q[1];
    end else if (uf2) begin
      cnt2_q <= rld2 ? load_q[1] : `CRT_ALL_ONES;
    end else if (tick2) begin
      cnt2_q <= cnt2_q - 8'h01;
    end
  end

  // Joint capture: the first counter latches with the same edge
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cap1_q <= `CRT_ALL_ONES;
      cap2_q <= `CRT_ALL_ONES;
    end else begin
      if (cap1) begin
        cap1_q <= cnt1_q;
      end
      if (cap2) begin
        cap2_q <= cnt2_q;
      end
    end
  end

  // FG mask: an acceleration underflow hides the next FG from the interrupt
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      fg_mask_q <= 1'b0;
    end else if (!accel) begin
      fg_mask_q <= 1'b0;
    end else if (uf2) begin
      fg_mask_q <= 1'b1;
    end else if (fg_rl2) begin
      fg_mask_q <= 1'b0;
    end
  end

  // Third counter
  assign tick3 = pick_tick(ps3, ctl_edge, div);
  assign uf3 = tick3 && (cnt3_q == `CRT_ZERO);
  assign reload3 = ctl_clk ? uf3 : ctl_edge;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt3_q <= `CRT_ALL_ONES;
    end else if (load_wr_i[2]) begin
      cnt3_q <= load_data_i;
    end else if (reload3) begin
      cnt3_q <= load_q[2];
    end else if (uf3) begin
      cnt3_q <= `CRT_ALL_ONES;
    end else if (tick3) begin
      cnt3_q <= cnt3_q - 8'h01;
    end
  end

  // One slow-track event per control edge, so a free-running wrap stays quiet
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      armed3_q <= 1'b0;
    end else if (ctl_clk) begin
      armed3_q <= 1'b0;
    end else if (ctl_edge) begin
      armed3_q <= 1'b1;
    end else if (uf3) begin
      armed3_q <= 1'b0;
    end
  end

  assign slw_ev = uf3 && armed3_q && !ctl_clk && !ctl_edge;

  // Flag events
  always_comb begin
    fi.set = '0;
    fi.set[`CRT_F_IRQ1] = uf1;
    fi.set[`CRT_F_IRQ2] = (uf2 && !accel) || (accel && fg_edge && !fg_mask_q);
    fi.set[`CRT_F_CAPTURE_EVENT_FLAG] = (cap1 || cap2) && !cp_slm;
    fi.set[`CRT_F_SLW] = slw_ev && cp_slm;
    fi.set[`CRT_F_REEL_PULSE_INPUT] = fi.set[`CRT_F_CAPTURE_EVENT_FLAG] | fi.set[`CRT_F_SLW];
  end

  assign fi.rd = flag_rd_i;
  assign fi.wr = flag_wr_i;
  assign fi.wdata = flag_data_i;
  assign fi.clr_cap_slw = mode_two_wr_i && (mode_data_i[`CRT_M2_CPSLM] != cp_slm);

  crt_flag_bank u_flags (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .fi(fi)
  );

  assign fg_divide_counter_o = cnt1_q;
  assign capture_speed_counter_o = cnt2_q;
  assign ctl_divide_counter_o = cnt3_q;
  assign capture_one_o = cap1_q;
  assign capture_two_o = cap2_q;
  assign timer_mode_reg_one_o = mode1_q;
  assign timer_mode_reg_two_o = mode2_q;
  assign flags_o = fi.flags;
  assign fg_mask_o = fg_mask_q;

  // Checks

  property p_load_all;
    @(posedge core_clk_i) disable iff (!nrst_i)
    load_wr_i[0] |=> (cnt1_q == $past(load_data_i)) && (load_q[0] == cnt1_q);
  endproperty
  a_load_all: assert property (p_load_all)
    else $error("reload write did not load first counter");

  property p_reload_one;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (uf1 && !cap_mode1 && !load_wr_i[0]) |=> (cnt1_q == $past(load_q[0]));
  endproperty
  a_reload_one: assert property (p_reload_one)
    else $error("first counter missed its reload");

  property p_joint_cap;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (cap_mode1 && mode2_q[`CRT_M2_LAT] && pin_cap)
      |=> (cap1_q == $past(cnt1_q)) && (cap2_q == $past(cnt2_q));
  endproperty
  a_joint_cap: assert property (p_joint_cap)
    else $error("joint capture not latched together");

  property p_cap_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (cap2 && clr_on_cap && !load_wr_i[1]) |=> (cnt2_q == `CRT_ALL_ONES);
  endproperty
  a_cap_clear: assert property (p_cap_clear)
    else $error("capture did not clear second counter");

  property p_irq1;
    @(posedge core_clk_i) disable iff (!nrst_i)
    uf1 |=> flags_o[`CRT_F_IRQ1] ##1 flags_o[`CRT_F_IRQ1] || $past(flag_wr_i);
  endproperty
  a_irq1: assert property (p_irq1)
    else $error("first underflow lost its interrupt");

  property p_reset_ones;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> (cnt1_q & cnt2_q & cnt3_q & cap1_q & cap2_q) == `CRT_ALL_ONES
      && mode1_q == `CRT_MODE_ONE_RST && mode2_q == `CRT_MODE_TWO_RST;
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("reset state wrong");

  sequence s_accel_uf;
    accel && uf2 && !load_wr_i[1] && !mode_one_wr_i;
  endsequence

  sequence s_masked_fg;
    fg_mask_q && accel && fg_edge && !load_wr_i[1] && !(cap2 && clr_on_cap);
  endsequence

  property p_accel_mask;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_accel_uf |=> fg_mask_q;
  endproperty
  a_accel_mask: assert property (p_accel_mask)
    else $error("acceleration underflow did not set FG mask");

  property p_masked_fg;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_masked_fg |=> !fg_mask_q && (cnt2_q == $past(load_q[1])) && !$rose(flags_o[`CRT_F_IRQ2]);
  endproperty
  a_masked_fg: assert property (p_masked_fg)
    else $error("masked FG mishandled");

  property p_accel_done;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (accel && fg_edge && !fg_mask_q && !load_wr_i[1] && !(cap2 && clr_on_cap))
      |=> (cnt2_q == $past(load_q[1])) && flags_o[`CRT_F_IRQ2];
  endproperty
  a_accel_done: assert property (p_accel_done)
    else $error("acceleration FG did not reload and interrupt");

  property p_brake_uf;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (ab_mode && !accel && uf2) |=> flags_o[`CRT_F_IRQ2];
  endproperty
  a_brake_uf: assert property (p_brake_uf)
    else $error("braking underflow did not interrupt");

  property p_slow_track;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (slw_ev && cp_slm) |=> flags_o[`CRT_F_SLW] && flags_o[`CRT_F_REEL_PULSE_INPUT];
  endproperty
  a_slow_track: assert property (p_slow_track)
    else $error("slow-track delay end not flagged");

  property p_mode_id;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (!mode2_q[`CRT_M2_LAT] && uf3) |=> (cap2_q == $past(cnt2_q));
  endproperty
  a_mode_id: assert property (p_mode_id)
    else $error("third underflow did not capture second counter");

  property p_ctl_reload;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (!ctl_clk && ctl_edge && !load_wr_i[2]) |=> (cnt3_q == $past(load_q[2]));
  endproperty
  a_ctl_reload: assert property (p_ctl_reload)
    else $error("control edge did not reload third counter");
endmodule
`default_nettype wire

// *** verilog/crt_defs.svh ***
// Constants of the capstan/reel timer trio: mode bit positions,
// reset values, prescaler taps and status flag positions.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CRT_DEFS_SVH
`define CRT_DEFS_SVH

`define CRT_ALL_ONES 8'hff
`define CRT_ZERO 8'h00
`define CRT_MODE_ONE_RST 8'h00
`define CRT_MODE_TWO_RST 8'h00

// Mode register one fields
`define CRT_M1_CLR 7
`define CRT_M1_ACBR 6
`define CRT_M1_RLD 5
`define CRT_M1_RLCK 4
`define CRT_M1_PS2_HI 3
`define CRT_M1_PS2_LO 2
`define CRT_M1_RLDCAP 1
`define CRT_M1_CPS 0

// Mode register two fields
`define CRT_M2_LAT 7
`define CRT_M2_PS1_HI 6
`define CRT_M2_PS1_LO 5
`define CRT_M2_PS3_HI 4
`define CRT_M2_PS3_LO 3
`define CRT_M2_CPSLM 2

// Status flags
`define CRT_NFLAG 5
`define CRT_F_IRQ1 0
`define CRT_F_IRQ2 1
`define CRT_F_REEL_PULSE_INPUT 2
`define CRT_F_CAPTURE_EVENT_FLAG 3
`define CRT_F_SLW 4

// Prescaler width and the three divided ticks (every 4, 16, 64 cycles)
`define CRT_PRE_W 6
`define CRT_DIV_A 6'h03
`define CRT_DIV_B 6'h0f
`define CRT_DIV_C 6'h3f

`endif

// *** verilog/crt_pkg.sv ***
// Types shared by the timer trio.
// Assumes crt_defs.svh is on the include path.
`default_nettype none
package crt_pkg;
  // Clock source select: the counter's own event or one of three divided clocks
  typedef enum logic [1:0] {
    CRT_SRC_EVT = 2'b00,
    CRT_SRC_DIV_A = 2'b01,
    CRT_SRC_DIV_B = 2'b10,
    CRT_SRC_DIV_C = 2'b11
  } crt_src_e;
  typedef logic [7:0] crt_byte_t;
endpackage
`default_nettype wire

// *** verilog/crt_flag_if.sv ***
// Carrier between the timer core and its status flag bank.
// Assumes both ends share core_clk_i.
`default_nettype none
`include "crt_defs.svh"
interface crt_flag_if;
  logic [`CRT_NFLAG-1:0] set;
  logic [`CRT_NFLAG-1:0] wdata;
  logic [`CRT_NFLAG-1:0] flags;
  logic rd;
  logic wr;
  logic clr_cap_slw;
  modport core (output set, wdata, rd, wr, clr_cap_slw, input flags);
  modport bank (input set, wdata, rd, wr, clr_cap_slw, output flags);
endinterface
`default_nettype wire

// *** verilog/crt_flag_bank.sv ***
// Sticky status flags of the timer trio with read-then-write-zero clearing.
// Assumes rd marks a software read of the flags in that same cycle.
`default_nettype none
`include "crt_defs.svh"
module crt_flag_bank
  import crt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  crt_flag_if.bank fi
);
  logic [`CRT_NFLAG-1:0] flag_q;
  logic [`CRT_NFLAG-1:0] seen_q;
  logic [`CRT_NFLAG-1:0] clr;

  // Capture and slow-track flags also drop when their select bit changes
  always_comb begin
    clr = fi.wr ? (~fi.wdata & seen_q) : '0;
    if (fi.clr_cap_slw) begin
      clr[`CRT_F_CAPTURE_EVENT_FLAG] = 1'b1;
      clr[`CRT_F_SLW] = 1'b1;
    end
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= fi.set | (flag_q & ~clr);
    end
  end

  // Remember which set flags software has seen
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      seen_q <= '0;
    end else begin
      seen_q <= (seen_q | (fi.rd ? flag_q : '0)) & flag_q & ~clr;
    end
  end

  assign fi.flags = flag_q;

  property p_no_blind_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (flag_q[`CRT_F_IRQ1] && !seen_q[`CRT_F_IRQ1] && !fi.rd && !fi.clr_cap_slw)
      |=> flag_q[`CRT_F_IRQ1];
  endproperty
  a_no_blind_clear: assert property (p_no_blind_clear)
    else $error("flag cleared without prior read");
endmodule
`default_nettype wire

// *** tb/crt_pulse_src.sv ***
// Pulse sources standing in for the FG, reel and control-track pins.
// Assumes fire_i strobes come from the bench on core_clk_i.
`default_nettype none
module crt_pulse_src (
  input wire logic core_clk_i,
  input wire logic [2:0] fire_i,
  output logic [2:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] level_q = 3'h0;
  logic [2:0] cnt_q [3] = '{3'h0, 3'h0, 3'h0};
  // Pins move 13 ns after the clock, so they stay unrelated to its edge
  assign #13 pin_o = level_q;
  always @(posedge core_clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (fire_i[i]) begin
        level_q[i] <= 1'h1;
        cnt_q[i] <= 3'h6;
      end else if (cnt_q[i] != 3'h0) begin
        cnt_q[i] <= cnt_q[i] - 3'h1;
      end else begin
        level_q[i] <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/test_crt_reel_timer_trio.sv ***
// Self-checking bench for the capstan/reel timer trio.
// Assumes the design files and crt_defs.svh are compiled first.
`default_nettype none
`include "crt_defs.svh"
module test_crt_reel_timer_trio
  import crt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int sel; logic [7:0] val;} crt_note_s;
  localparam logic [7:0] F_IRQ1 = 8'h01 << `CRT_F_IRQ1;
  localparam logic [7:0] F_IRQ2 = 8'h01 << `CRT_F_IRQ2;
  localparam logic [7:0] F_REEL_PULSE_INPUT = 8'h01 << `CRT_F_REEL_PULSE_INPUT;
  localparam logic [7:0] F_CAPTURE_EVENT_FLAG = 8'h01 << `CRT_F_CAPTURE_EVENT_FLAG;
  localparam logic [7:0] F_SLW = 8'h01 << `CRT_F_SLW;
  logic core_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [2:0] fire = 3'h0;
  wire logic [2:0] pins;
  logic [2:0] load_wr_i = 3'h0;
  logic [7:0] load_data_i = 8'h00;
  logic mode_one_wr_i = 1'h0;
  logic mode_two_wr_i = 1'h0;
  logic [7:0] mode_data_i = 8'h00;
  logic flag_rd_i = 1'h0;
  logic flag_wr_i = 1'h0;
  logic [`CRT_NFLAG-1:0] flag_data_i = 5'h00;
  logic [7:0] cnt1, cnt2, cnt3, cap1, cap2, m1, m2;
  logic [`CRT_NFLAG-1:0] flags;
  logic mask;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  crt_note_s notes[$];
  event note_ev;
  logic [7:0] d [3];
  logic [7:0] c1;

  crt_reel_timer_trio dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .fg_pulse_i(pins[0]),
    .reel_pulse_input_i(pins[1]), .divided_ctl_pulse_i(pins[2]),
    .load_wr_i(load_wr_i), .load_data_i(load_data_i), .mode_one_wr_i(mode_one_wr_i),
    .mode_two_wr_i(mode_two_wr_i), .mode_data_i(mode_data_i), .flag_rd_i(flag_rd_i),
    .flag_wr_i(flag_wr_i), .flag_data_i(flag_data_i), .fg_divide_counter_o(cnt1),
    .capture_speed_counter_o(cnt2), .ctl_divide_counter_o(cnt3), .capture_one_o(cap1),
    .capture_two_o(cap2), .timer_mode_reg_one_o(m1), .timer_mode_reg_two_o(m2),
    .flags_o(flags), .fg_mask_o(mask)
  );
  crt_pulse_src src (.core_clk_i(core_clk_i), .fire_i(fire), .pin_o(pins));

  always #25 core_clk_i = ~core_clk_i;

  task automatic stop_test();
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang ends here rather than running forever
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] get_out(input int sel);
    case (sel)
      0: return cnt1;
      1: return cnt2;
      2: return cnt3;
      3: return cap1;
      4: return cap2;
      5: return m1;
      6: return m2;
      7: return 8'(flags);
      default: return 8'(mask);
    endcase
  endfunction

  task automatic note(input int sel, input logic [7:0] val);
    notes.push_back('{sel, val});
    -> note_ev;
  endtask

  always @(note_ev) begin
    while (notes.size() > 0) begin
      check(get_out(notes[0].sel), notes[0].val);
      void'(notes.pop_front());
    end
  end

  task automatic load(input int k, input logic [7:0] v);
    @(posedge core_clk_i);
    load_wr_i <= 3'(1 << k);
    load_data_i <= v;
    @(posedge core_clk_i);
    load_wr_i <= 3'h0;
    @(negedge core_clk_i);
  endtask

  task automatic set_mode(input logic two, input logic [7:0] v);
    @(posedge core_clk_i);
    mode_one_wr_i <= ~two;
    mode_two_wr_i <= two;
    mode_data_i <= v;
    @(posedge core_clk_i);
    mode_one_wr_i <= 1'h0;
    mode_two_wr_i <= 1'h0;
    @(negedge core_clk_i);
  endtask

  task automatic flag_op(input logic rd, input logic wr);
    @(posedge core_clk_i);
    flag_rd_i <= rd;
    flag_wr_i <= wr;
    flag_data_i <= 5'h00;
    @(posedge core_clk_i);
    flag_rd_i <= 1'h0;
    flag_wr_i <= 1'h0;
    @(negedge core_clk_i);
  endtask

  task automatic clear_flags();
    flag_op(1'h1, 1'h0);
    flag_op(1'h0, 1'h1);
  endtask

  // Gap after each pulse lets the synchroniser see the fall before the next rise
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      fire <= 3'(1 << k);
      @(posedge core_clk_i);
      fire <= 3'h0;
      repeat (14) @(posedge core_clk_i);
    end
    @(negedge core_clk_i);
  endtask

  initial begin
    void'($urandom(32'h20a31d36));
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    @(negedge core_clk_i);
    for (int s = 0; s < 9; s++) begin
      note(s, (s < 5) ? 8'hff : 8'h00);
    end
    for (int k = 0; k < 3; k++) begin
      d[k] = 8'(($urandom % 255) + 1);
      load(k, d[k]);
      note(k, d[k]);
    end
    load(0, 8'h02);
    load(2, 8'h01);
    pulse(0, 3);
    note(0, 8'h02);
    note(1, d[1] - 8'h01);
    note(7, F_IRQ1);
    clear_flags();
    pulse(2, 2);
    note(2, 8'h01);
    note(4, d[1] - 8'h01);
    note(7, F_CAPTURE_EVENT_FLAG | F_REEL_PULSE_INPUT);
    flag_op(1'h0, 1'h1);
    note(7, F_CAPTURE_EVENT_FLAG | F_REEL_PULSE_INPUT);
    clear_flags();
    note(7, 8'h00);
    set_mode(1'h0, 8'h03);
    set_mode(1'h1, 8'h80);
    note(5, 8'h03);
    note(6, 8'h80);
    c1 = 8'($urandom);
    load(0, c1);
    pulse(1, 1);
    note(3, c1);
    note(4, d[1] - 8'h01);
    note(7, F_CAPTURE_EVENT_FLAG | F_REEL_PULSE_INPUT);
    set_mode(1'h0, 8'h83);
    pulse(1, 1);
    note(4, d[1] - 8'h01);
    note(1, 8'hff);
    clear_flags();
    set_mode(1'h1, 8'h00);
    set_mode(1'h0, 8'h64);
    load(0, 8'hff);
    load(1, 8'h30);
    pulse(0, 1);
    note(7, F_IRQ2);
    note(8, 8'h00);
    clear_flags();
    repeat (260) @(negedge core_clk_i);
    note(8, 8'h01);
    note(7, 8'h00);
    pulse(0, 1);
    note(8, 8'h00);
    note(7, 8'h00);
    set_mode(1'h0, 8'h24);
    load(1, 8'h30);
    pulse(0, 5);
    note(7, 8'h00);
    repeat (260) @(negedge core_clk_i);
    note(7, F_IRQ2);
    set_mode(1'h0, 8'h00);
    set_mode(1'h1, 8'h8c);
    clear_flags();
    load(2, 8'h20);
    repeat (60) @(negedge core_clk_i);
    pulse(2, 1);
    repeat (90) @(negedge core_clk_i);
    note(7, 8'h00);
    repeat (60) @(negedge core_clk_i);
    note(7, F_SLW | F_REEL_PULSE_INPUT);
    @(posedge core_clk_i);
    stop_test();
  end
endmodule
`default_nettype wire
